//--- src/ofd_pkg.sv
package ofd_pkg;
  localparam int WORD_W = 16;
  localparam int STACK_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam logic [2:0] TOP_RESET = 3'h7;
  // Conventional numbering: leftmost bit 0 sits at vector index 15
  localparam int SIGN_POS = WORD_W - 1 - 0;
  localparam logic [15:0] WORD_ADDR_LAST = 16'hffff;
  localparam logic [15:0] BYTE_WORD_LAST = 16'h7fff;
  localparam logic [15:0] SIGNED_WORD_MIN = 16'h8000;
  localparam logic [15:0] SIGNED_WORD_MAX = 16'h7fff;
  localparam logic [31:0] SIGNED_DOUBLE_MIN = 32'h80000000;
  localparam logic [31:0] SIGNED_DOUBLE_MAX = 32'h7fffffff;
  localparam logic [31:0] DOUBLE_MINUS_ONE = 32'hffffffff;
  localparam logic [31:0] DOUBLE_ZERO = 32'h00000000;
  localparam logic [31:0] DOUBLE_ONE = 32'h00000001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] LANES_LEFT = 2'h2;
  localparam logic [1:0] LANES_RIGHT = 2'h1;
  localparam logic [1:0] LANES_BOTH = 2'h3;

  typedef enum logic [4:0] {
    OFD_OP_NOP = 5'h00,
    OFD_OP_PUSH_LITERAL = 5'h01,
    OFD_OP_LOAD_WORD_FROM_DATA = 5'h02,
    OFD_OP_LOAD_WORD_FROM_CODE = 5'h03,
    OFD_OP_STORE_WORD_TO_DATA = 5'h04,
    OFD_OP_NONDESTRUCTIVE_WORD_STORE = 5'h05,
    OFD_OP_LOAD_BYTE_FROM_DATA = 5'h06,
    OFD_OP_LOAD_BYTE_FROM_CODE = 5'h07,
    OFD_OP_STORE_BYTE_TO_DATA = 5'h08,
    OFD_OP_LOAD_DOUBLE_FROM_DATA = 5'h09,
    OFD_OP_STORE_DOUBLE_TO_DATA = 5'h0a,
    OFD_OP_LOAD_QUAD_FROM_DATA = 5'h0b,
    OFD_OP_STORE_QUAD_TO_DATA = 5'h0c,
    OFD_OP_SIGNED_ADD = 5'h0d,
    OFD_OP_SIGNED_SUBTRACT = 5'h0e,
    OFD_OP_UNSIGNED_ADD = 5'h0f,
    OFD_OP_UNSIGNED_SUBTRACT = 5'h10,
    OFD_OP_SIGNED_TWOS_COMPLEMENT_NEGATE = 5'h11,
    OFD_OP_UNSIGNED_ONES_COMPLEMENT_NEGATE = 5'h12,
    OFD_OP_UNSIGNED_MULTIPLY = 5'h13,
    OFD_OP_UNSIGNED_DIVIDE = 5'h14,
    OFD_OP_SIGNED_DOUBLE_ADD = 5'h15,
    OFD_OP_PUSH_DOUBLE_MINUS_ONE = 5'h16,
    OFD_OP_PUSH_DOUBLE_ZERO = 5'h17,
    OFD_OP_PUSH_DOUBLE_ONE = 5'h18
  } ofd_op_e;

  typedef enum logic [0:0] {
    OFD_S_IDLE = 1'b0,
    OFD_S_MEM = 1'b1
  } ofd_fsm_e;

  typedef struct packed {
    ofd_op_e op;
    logic [15:0] operand;
  } ofd_cmd_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic code_seg;
    logic [1:0] lanes;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ofd_mem_req_s;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } ofd_mem_rsp_s;

  typedef struct packed {
    logic neg;
    logic zero;
    logic carry;
    logic overflow;
  } ofd_flags_s;

  typedef struct packed {
    logic busy;
    logic [2:0] top;
    logic [15:0] top_word;
    ofd_flags_s flags;
  } ofd_status_s;

  typedef struct packed {
    ofd_fsm_e fsm;
    logic [STACK_DEPTH-1:0][WORD_W-1:0] stack;
    logic [2:0] top;
    ofd_op_e op;
    logic [15:0] base;
    logic [1:0] idx;
    logic [1:0] last;
    logic byte_right;
    ofd_flags_s flags;
  } ofd_state_s;

  // Stack words consumed by an operation
  function automatic logic [2:0] op_pops(input ofd_op_e op);
    case (op)
      OFD_OP_STORE_WORD_TO_DATA, OFD_OP_STORE_BYTE_TO_DATA,
      OFD_OP_SIGNED_TWOS_COMPLEMENT_NEGATE,
      OFD_OP_UNSIGNED_ONES_COMPLEMENT_NEGATE: return 3'h1;
      OFD_OP_STORE_DOUBLE_TO_DATA, OFD_OP_SIGNED_ADD, OFD_OP_SIGNED_SUBTRACT,
      OFD_OP_UNSIGNED_ADD, OFD_OP_UNSIGNED_SUBTRACT, OFD_OP_UNSIGNED_MULTIPLY,
      OFD_OP_UNSIGNED_DIVIDE: return 3'h2;
      OFD_OP_STORE_QUAD_TO_DATA, OFD_OP_SIGNED_DOUBLE_ADD: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

  // Result words left by an arithmetic operation
  function automatic logic [2:0] op_pushes(input ofd_op_e op);
    case (op)
      OFD_OP_SIGNED_ADD, OFD_OP_SIGNED_SUBTRACT, OFD_OP_UNSIGNED_ADD,
      OFD_OP_UNSIGNED_SUBTRACT, OFD_OP_SIGNED_TWOS_COMPLEMENT_NEGATE,
      OFD_OP_UNSIGNED_ONES_COMPLEMENT_NEGATE: return 3'h1;
      OFD_OP_UNSIGNED_MULTIPLY, OFD_OP_UNSIGNED_DIVIDE, OFD_OP_SIGNED_DOUBLE_ADD,
      OFD_OP_PUSH_DOUBLE_MINUS_ONE, OFD_OP_PUSH_DOUBLE_ZERO,
      OFD_OP_PUSH_DOUBLE_ONE: return 3'h2;
      default: return 3'h0;
    endcase
  endfunction
endpackage

//--- src/ofd_alu.sv
`timescale 1ns/10ps
`default_nettype none
module ofd_alu
  import ofd_pkg::*;
(
  input wire ofd_op_e op,
  input wire logic [15:0] w0,
  input wire logic [15:0] w1,
  input wire logic [15:0] w2,
  input wire logic [15:0] w3,
  output logic [15:0] res_ms,
  output logic [15:0] res_ls,
  output ofd_flags_s flags
);
  logic [16:0] sum17;
  logic [32:0] sum33;
  logic [31:0] y32;

  // w0 is the top word, w1 the one beneath it
  always_comb begin
    sum17 = 17'h00000;
    sum33 = 33'h000000000;
    y32 = 32'h00000000;
    res_ms = 16'h0000;
    res_ls = 16'h0000;
    flags = '0;
    case (op)
      OFD_OP_SIGNED_ADD, OFD_OP_UNSIGNED_ADD: begin
        sum17 = {1'b0, w1} + {1'b0, w0};
        res_ls = sum17[15:0];
        flags.carry = sum17[16];
        // Only the integer class reports overflow
        flags.overflow = (op == OFD_OP_SIGNED_ADD) && (w1[SIGN_POS] == w0[SIGN_POS])
          && (sum17[SIGN_POS] != w1[SIGN_POS]);
      end
      OFD_OP_SIGNED_SUBTRACT, OFD_OP_UNSIGNED_SUBTRACT: begin
        sum17 = {1'b0, w1} + {1'b0, ~w0} + 17'h00001;
        res_ls = sum17[15:0];
        flags.carry = sum17[16];
        flags.overflow = (op == OFD_OP_SIGNED_SUBTRACT) && (w1[SIGN_POS] != w0[SIGN_POS])
          && (sum17[SIGN_POS] != w1[SIGN_POS]);
      end
      OFD_OP_SIGNED_TWOS_COMPLEMENT_NEGATE: begin
        res_ls = ~w0 + 16'h0001;
        flags.overflow = (w0 == SIGNED_WORD_MIN);
      end
      OFD_OP_UNSIGNED_ONES_COMPLEMENT_NEGATE: begin
        res_ls = ~w0;
      end
      OFD_OP_UNSIGNED_MULTIPLY: begin
        // Operands widened first so the full doubleword product is kept
        {res_ms, res_ls} = {16'h0000, w1} * {16'h0000, w0};
      end
      OFD_OP_UNSIGNED_DIVIDE: begin
        // Zero divisor flags overflow and leaves zeros
        flags.overflow = (w0 == 16'h0000);
        if (w0 != 16'h0000) begin
          res_ms = w1 / w0;
          res_ls = w1 % w0;
        end
      end
      OFD_OP_SIGNED_DOUBLE_ADD: begin
        y32 = {w1, w0};
        sum33 = {1'b0, w3, w2} + {1'b0, y32};
        {res_ms, res_ls} = sum33[31:0];
        flags.carry = sum33[32];
        flags.overflow = (w3[SIGN_POS] == w1[SIGN_POS])
          && (sum33[31] != w3[SIGN_POS]);
      end
      OFD_OP_PUSH_DOUBLE_MINUS_ONE: {res_ms, res_ls} = DOUBLE_MINUS_ONE;
      OFD_OP_PUSH_DOUBLE_ZERO: {res_ms, res_ls} = DOUBLE_ZERO;
      OFD_OP_PUSH_DOUBLE_ONE: {res_ms, res_ls} = DOUBLE_ONE;
      default: res_ls = 16'h0000;
    endcase
    // Sign lives in the leftmost bit of the most significant word
    if (op_pushes(op) == 3'h2) begin
      flags.neg = res_ms[SIGN_POS];
      flags.zero = ({res_ms, res_ls} == DOUBLE_ZERO);
    end else begin
      flags.neg = res_ls[SIGN_POS];
      flags.zero = (res_ls == 16'h0000);
    end
  end
endmodule
`default_nettype wire

//--- src/ofd_operand_datapath.sv
`timescale 1ns/10ps
`default_nettype none
module ofd_operand_datapath
  import ofd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire ofd_cmd_s cmd,
  output logic cmd_ready,
  input wire logic [15:0] pc,
  output ofd_mem_req_s mem_req,
  input wire ofd_mem_rsp_s mem_rsp,
  output ofd_status_s status
);
  ofd_state_s st;
  ofd_state_s next_st;
  logic accept;
  logic [15:0] w0;
  logic [15:0] w1;
  logic [15:0] w2;
  logic [15:0] w3;
  logic [15:0] alu_ms;
  logic [15:0] alu_ls;
  ofd_flags_s alu_flags;
  logic [2:0] new_top;
  logic is_load;
  logic [15:0] load_word;
  logic [2:0] store_pos;

  // Top four stack words, pointer arithmetic wraps in three bits
  assign w0 = st.stack[st.top];
  assign w1 = st.stack[st.top - 3'h1];
  assign w2 = st.stack[st.top - 3'h2];
  assign w3 = st.stack[st.top - 3'h3];

  ofd_alu u_alu (
    .op(cmd.op),
    .w0(w0),
    .w1(w1),
    .w2(w2),
    .w3(w3),
    .res_ms(alu_ms),
    .res_ls(alu_ls),
    .flags(alu_flags)
  );

  // Handshake: one command at a time, memory work stalls the next
  assign cmd_ready = (st.fsm == OFD_S_IDLE);
  assign accept = cmd_valid && cmd_ready;

  assign is_load = (st.op == OFD_OP_LOAD_WORD_FROM_DATA) || (st.op == OFD_OP_LOAD_WORD_FROM_CODE)
    || (st.op == OFD_OP_LOAD_BYTE_FROM_DATA) || (st.op == OFD_OP_LOAD_BYTE_FROM_CODE)
    || (st.op == OFD_OP_LOAD_DOUBLE_FROM_DATA) || (st.op == OFD_OP_LOAD_QUAD_FROM_DATA);

  // Byte loads keep the chosen half, left half forced to zero
  always_comb begin
    load_word = mem_rsp.rdata;
    if ((st.op == OFD_OP_LOAD_BYTE_FROM_DATA) || (st.op == OFD_OP_LOAD_BYTE_FROM_CODE)) begin
      if (st.byte_right) begin
        load_word = {BYTE_ZERO, mem_rsp.rdata[7:0]};
      end else begin
        load_word = {BYTE_ZERO, mem_rsp.rdata[15:8]};
      end
    end
  end

  // Multiword stores send the most significant word first
  assign store_pos = st.top - {1'b0, st.last} + {1'b0, st.idx};

  // Memory request comes straight from the held state
  always_comb begin
    mem_req = '0;
    mem_req.valid = (st.fsm == OFD_S_MEM);
    mem_req.write = !is_load;
    mem_req.code_seg = (st.op == OFD_OP_LOAD_WORD_FROM_CODE)
      || (st.op == OFD_OP_LOAD_BYTE_FROM_CODE);
    mem_req.addr = st.base + {14'h0000, st.idx};
    mem_req.lanes = LANES_BOTH;
    mem_req.wdata = st.stack[store_pos];
    if (st.op == OFD_OP_STORE_BYTE_TO_DATA) begin
      // Byte copied to both halves; lanes pick the half actually written
      mem_req.wdata = {w0[7:0], w0[7:0]};
      mem_req.lanes = st.byte_right ? LANES_RIGHT : LANES_LEFT;
    end
  end

  // Status mirrors state registers
  always_comb begin
    status.busy = (st.fsm == OFD_S_MEM);
    status.top = st.top;
    status.top_word = w0;
    status.flags = st.flags;
  end

  // Next-state logic for the whole datapath
  always_comb begin
    next_st = st;
    new_top = st.top - op_pops(cmd.op) + op_pushes(cmd.op);
    case (st.fsm)
      OFD_S_IDLE: begin
        if (accept) begin
          next_st.op = cmd.op;
          next_st.idx = 2'h0;
          next_st.last = 2'h0;
          next_st.byte_right = 1'b0;
          next_st.base = cmd.operand;
          case (cmd.op)
            OFD_OP_PUSH_LITERAL: begin
              next_st.top = st.top + 3'h1;
              next_st.stack[st.top + 3'h1] = cmd.operand;
            end
            OFD_OP_LOAD_WORD_FROM_DATA, OFD_OP_LOAD_WORD_FROM_CODE,
            OFD_OP_STORE_WORD_TO_DATA, OFD_OP_NONDESTRUCTIVE_WORD_STORE: begin
              next_st.fsm = OFD_S_MEM;
            end
            OFD_OP_LOAD_BYTE_FROM_DATA, OFD_OP_STORE_BYTE_TO_DATA: begin
              // Data byte space covers only the lower half of the segment
              next_st.fsm = OFD_S_MEM;
              next_st.byte_right = cmd.operand[0];
              next_st.base = {1'b0, cmd.operand[15:1]};
            end
            OFD_OP_LOAD_BYTE_FROM_CODE: begin
              // Half of code space follows the running program
              next_st.fsm = OFD_S_MEM;
              next_st.byte_right = cmd.operand[0];
              next_st.base = {pc[15], cmd.operand[15:1]};
            end
            OFD_OP_LOAD_DOUBLE_FROM_DATA, OFD_OP_STORE_DOUBLE_TO_DATA: begin
              next_st.fsm = OFD_S_MEM;
              next_st.last = 2'h1;
            end
            OFD_OP_LOAD_QUAD_FROM_DATA, OFD_OP_STORE_QUAD_TO_DATA: begin
              next_st.fsm = OFD_S_MEM;
              next_st.last = 2'h3;
            end
            OFD_OP_NOP: begin
              next_st.top = st.top;
            end
            default: begin
              // Operands leave, results take their place
              next_st.top = new_top;
              if (op_pushes(cmd.op) == 3'h2) begin
                next_st.stack[new_top - 3'h1] = alu_ms;
                next_st.stack[new_top] = alu_ls;
              end else begin
                next_st.stack[new_top] = alu_ls;
              end
              next_st.flags = alu_flags;
            end
          endcase
        end
      end
      OFD_S_MEM: begin
        if (mem_rsp.ack) begin
          if (is_load) begin
            // Each arriving word is pushed, most significant first
            next_st.top = st.top + 3'h1;
            next_st.stack[st.top + 3'h1] = load_word;
          end
          if (st.idx == st.last) begin
            next_st.fsm = OFD_S_IDLE;
            if (!is_load) begin
              // Non-destructive store pops nothing
              next_st.top = st.top - op_pops(st.op);
            end
          end else begin
            next_st.idx = st.idx + 2'h1;
          end
        end
      end
      default: next_st.fsm = OFD_S_IDLE;
    endcase
  end

  // State register; stack contents cleared so reads are defined
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.top <= TOP_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Checks on the datapath
  sequence s_take_op(ofd_op_e o);
    accept && (cmd.op == o);
  endsequence

  sequence s_mem_done;
    (st.fsm == OFD_S_MEM) && mem_rsp.ack && (st.idx == st.last);
  endsequence

  property p_push_advances;
    @(posedge clk) disable iff (!rst_n)
    s_take_op(OFD_OP_PUSH_LITERAL) |=> (st.top == $past(st.top) + 3'h1)
      && (w0 == $past(cmd.operand));
  endproperty
  a_push_advances: assert property (p_push_advances)
    else $error("push did not advance top");

  property p_binary_replaces;
    @(posedge clk) disable iff (!rst_n)
    s_take_op(OFD_OP_UNSIGNED_ADD) |=> (st.top == $past(st.top) - 3'h1)
      && (w0 == 16'($past(w1) + $past(w0)));
  endproperty
  a_binary_replaces: assert property (p_binary_replaces)
    else $error("add did not replace operands");

  property p_signed_overflow;
    @(posedge clk) disable iff (!rst_n)
    s_take_op(OFD_OP_SIGNED_ADD) ##0 ((w1 == SIGNED_WORD_MAX) && (w0 == 16'h0001))
      |=> st.flags.overflow && st.flags.neg;
  endproperty
  a_signed_overflow: assert property (p_signed_overflow)
    else $error("signed overflow missed");

  property p_logical_no_overflow;
    @(posedge clk) disable iff (!rst_n)
    s_take_op(OFD_OP_UNSIGNED_ADD) |=> !st.flags.overflow;
  endproperty
  a_logical_no_overflow: assert property (p_logical_no_overflow)
    else $error("logical add overflowed");

  property p_negates;
    @(posedge clk) disable iff (!rst_n)
    s_take_op(OFD_OP_UNSIGNED_ONES_COMPLEMENT_NEGATE) |=> (w0 == ~$past(w0))
      && (st.top == $past(st.top));
  endproperty
  a_negates: assert property (p_negates)
    else $error("ones complement negate wrong");

  property p_twos_negate;
    @(posedge clk) disable iff (!rst_n)
    s_take_op(OFD_OP_SIGNED_TWOS_COMPLEMENT_NEGATE) |=> (w0 == 16'(~$past(w0) + 16'h0001));
  endproperty
  a_twos_negate: assert property (p_twos_negate)
    else $error("twos complement negate wrong");

  property p_multiply;
    @(posedge clk) disable iff (!rst_n)
    s_take_op(OFD_OP_UNSIGNED_MULTIPLY) |=> ({w1, w0} == $past(w1) * $past(w0))
      && (st.top == $past(st.top));
  endproperty
  a_multiply: assert property (p_multiply)
    else $error("multiply product wrong");

  property p_double_minus_one;
    @(posedge clk) disable iff (!rst_n)
    s_take_op(OFD_OP_PUSH_DOUBLE_MINUS_ONE) |=> ({w1, w0} == DOUBLE_MINUS_ONE)
      && (st.top == $past(st.top) + 3'h2);
  endproperty
  a_double_minus_one: assert property (p_double_minus_one)
    else $error("minus one push wrong");

  property p_data_byte_addr;
    @(posedge clk) disable iff (!rst_n)
    s_take_op(OFD_OP_LOAD_BYTE_FROM_DATA) |=> mem_req.valid
      && (mem_req.addr == {1'b0, $past(cmd.operand[15:1])}) && (mem_req.addr <= BYTE_WORD_LAST);
  endproperty
  a_data_byte_addr: assert property (p_data_byte_addr)
    else $error("data byte address wrong");

  property p_code_byte_addr;
    @(posedge clk) disable iff (!rst_n)
    s_take_op(OFD_OP_LOAD_BYTE_FROM_CODE) |=> mem_req.code_seg
      && (mem_req.addr == {$past(pc[15]), $past(cmd.operand[15:1])});
  endproperty
  a_code_byte_addr: assert property (p_code_byte_addr)
    else $error("code byte address wrong");

  property p_nondestructive;
    @(posedge clk) disable iff (!rst_n)
    (st.op == OFD_OP_NONDESTRUCTIVE_WORD_STORE) and s_mem_done
      |-> (mem_req.wdata == w0) ##1 (st.top == $past(st.top)) && (w0 == $past(w0));
  endproperty
  a_nondestructive: assert property (p_nondestructive)
    else $error("store removed top word");

  property p_quad_walk;
    @(posedge clk) disable iff (!rst_n)
    s_take_op(OFD_OP_LOAD_QUAD_FROM_DATA) |=> (st.last == 2'h3)
      && (mem_req.addr == $past(cmd.operand)) && !mem_req.write;
  endproperty
  a_quad_walk: assert property (p_quad_walk)
    else $error("quad load start wrong");

  property p_load_done;
    @(posedge clk) disable iff (!rst_n)
    (st.op == OFD_OP_LOAD_DOUBLE_FROM_DATA) and s_mem_done |=> cmd_ready
      && (w0 == $past(mem_rsp.rdata));
  endproperty
  a_load_done: assert property (p_load_done)
    else $error("double load finish wrong");
endmodule
`default_nettype wire

//--- test/ofd_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Memory partner: word-wide code and data segments, one ack per word
module ofd_mem_model
  import ofd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire ofd_mem_req_s mem_req,
  output ofd_mem_rsp_s mem_rsp
);
  logic [15:0] dmem [0:65535];
  logic [15:0] cmem [0:65535];
  logic [15:0] w;
  // Slow mode stalls at random; an idle data bus toggles so stale reads show up
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rsp <= '0;
    end else if (mem_req.valid && !mem_rsp.ack && !(slow && $urandom_range(0, 2) != 0)) begin
      w = mem_req.code_seg ? cmem[mem_req.addr] : dmem[mem_req.addr];
      mem_rsp <= '{ack: 1'b1, rdata: w};
    end else begin
      // Write lands at the edge the unit sees the ack
      if (mem_rsp.ack && mem_req.valid && mem_req.write && !mem_req.code_seg) begin
        w = dmem[mem_req.addr];
        if (mem_req.lanes[1]) w[15:8] = mem_req.wdata[15:8];
        if (mem_req.lanes[0]) w[7:0] = mem_req.wdata[7:0];
        dmem[mem_req.addr] <= w;
      end
      mem_rsp <= '{ack: 1'b0, rdata: ~mem_rsp.rdata};
    end
  end
endmodule
`default_nettype wire

//--- test/operand_format_datapath_test.sv
`timescale 1ns/10ps
`default_nettype none
module operand_format_datapath_test;
  import ofd_pkg::*;
  typedef struct packed {
    logic chk;
    logic full;
    logic [2:0] nzc;
    logic ovf;
    logic [2:0] top;
    logic [15:0] word;
  } ofd_note_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  ofd_cmd_s cmd = '0;
  logic cmd_ready;
  logic [15:0] pc = 16'h0000;
  logic slow = 1'b0;
  ofd_mem_req_s mem_req;
  ofd_mem_rsp_s mem_rsp;
  ofd_status_s status;
  ofd_note_s notes [$];
  ofd_note_s n;
  logic [15:0] ms [8];
  logic [2:0] mt = 3'h7;
  logic taken = 1'b0;
  logic pend = 1'b0;
  logic [15:0] x;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;

  ofd_operand_datapath dut_u (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .pc(pc), .mem_req(mem_req), .mem_rsp(mem_rsp), .status(status));
  ofd_mem_model mem_u (.clk(clk), .rst_n(rst_n), .slow(slow), .mem_req(mem_req),
    .mem_rsp(mem_rsp));

  always #5 clk = ~clk;

  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic void mpush(input logic [15:0] w);
    mt = mt + 3'h1;
    ms[mt] = w;
  endfunction

  // Reference stack model, then offer the command; valid stays up for back-to-back use
  task automatic run(input ofd_op_e o, input logic [15:0] v);
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] w;
    logic [31:0] p;
    logic s;
    logic c;
    logic k;
    logic f;
    logic [2:0] z;
    a = ms[mt - 3'h1];
    b = ms[mt];
    w = mem_u.dmem[{1'b0, v[15:1]}];
    c = 1'b0;
    k = 1'b0;
    f = 1'b0;
    z = 3'h0;
    s = (o == OFD_OP_SIGNED_SUBTRACT || o == OFD_OP_UNSIGNED_SUBTRACT);
    case (o)
      OFD_OP_PUSH_LITERAL: mpush(v);
      OFD_OP_LOAD_WORD_FROM_DATA: mpush(mem_u.dmem[v]);
      OFD_OP_LOAD_WORD_FROM_CODE: mpush(mem_u.cmem[v]);
      OFD_OP_STORE_WORD_TO_DATA, OFD_OP_STORE_BYTE_TO_DATA: mt = mt - 3'h1;
      OFD_OP_STORE_DOUBLE_TO_DATA: mt = mt - 3'h2;
      OFD_OP_STORE_QUAD_TO_DATA: mt = mt - 3'h4;
      OFD_OP_LOAD_BYTE_FROM_DATA: mpush({8'h00, v[0] ? w[7:0] : w[15:8]});
      OFD_OP_LOAD_BYTE_FROM_CODE: begin
        w = mem_u.cmem[{pc[15], v[15:1]}];
        mpush({8'h00, v[0] ? w[7:0] : w[15:8]});
      end
      OFD_OP_LOAD_DOUBLE_FROM_DATA, OFD_OP_LOAD_QUAD_FROM_DATA: begin
        for (int i = 0; i < (o == OFD_OP_LOAD_QUAD_FROM_DATA ? 4 : 2); i++) begin
          mpush(mem_u.dmem[v + 16'(i)]);
        end
      end
      OFD_OP_SIGNED_ADD, OFD_OP_UNSIGNED_ADD, OFD_OP_SIGNED_SUBTRACT,
      OFD_OP_UNSIGNED_SUBTRACT: begin
        w = s ? a - b : a + b;
        k = 1'b1;
        f = 1'b1;
        // Negative, zero, and carry out (no borrow on subtract)
        z = {w[15], w == 16'h0000, s ? (a >= b) : (17'(a) + 17'(b) > 17'h0ffff)};
        c = (o == OFD_OP_SIGNED_ADD || o == OFD_OP_SIGNED_SUBTRACT)
          && ((a[15] ^ b[15]) == s) && (w[15] != a[15]);
        mt = mt - 3'h1;
        ms[mt] = w;
      end
      OFD_OP_SIGNED_TWOS_COMPLEMENT_NEGATE: begin
        ms[mt] = -b;
        k = 1'b1;
        c = (b == 16'h8000);
      end
      OFD_OP_UNSIGNED_ONES_COMPLEMENT_NEGATE: ms[mt] = ~b;
      OFD_OP_UNSIGNED_MULTIPLY: {ms[mt - 3'h1], ms[mt]} = {16'h0000, a} * {16'h0000, b};
      OFD_OP_UNSIGNED_DIVIDE: begin
        // Zero divisor leaves zeros and raises overflow
        k = 1'b1;
        c = (b == 16'h0000);
        {ms[mt - 3'h1], ms[mt]} = c ? 32'h00000000 : {a / b, a % b};
      end
      OFD_OP_SIGNED_DOUBLE_ADD: begin
        w = ms[mt - 3'h3];
        p = {w, ms[mt - 3'h2]} + {a, b};
        k = 1'b1;
        c = (w[15] == a[15]) && (p[31] != a[15]);
        mt = mt - 3'h2;
        {ms[mt - 3'h1], ms[mt]} = p;
      end
      OFD_OP_PUSH_DOUBLE_MINUS_ONE: {ms[mt + 3'h1], ms[mt + 3'h2]} = 32'hffffffff;
      OFD_OP_PUSH_DOUBLE_ZERO: {ms[mt + 3'h1], ms[mt + 3'h2]} = 32'h00000000;
      OFD_OP_PUSH_DOUBLE_ONE: {ms[mt + 3'h1], ms[mt + 3'h2]} = 32'h00000001;
      default: ;
    endcase
    if (o >= OFD_OP_PUSH_DOUBLE_MINUS_ONE) mt = mt + 3'h2;
    notes.push_back('{k, f, z, c, mt, ms[mt]});
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{op: o, operand: v};
    // Ready comes from state, so high at a falling edge means taken at the next rise
    while (!cmd_ready) @(negedge clk);
    @(posedge clk);
  endtask

  task automatic wait_idle();
    @(negedge clk);
    cmd_valid = 1'b0;
    while (!cmd_ready) @(negedge clk);
  endtask

  // Take the oldest note once the unit is idle after the command that made it
  always @(posedge clk) taken <= rst_n && cmd_valid && cmd_ready;
  initial begin
    forever begin
      @(negedge clk);
      pend = pend | taken;
      if (pend && cmd_ready) begin
        pend = 1'b0;
        n = notes.pop_front();
        cmp("stack top", 16'(n.top), 16'(status.top));
        cmp("top word", n.word, status.top_word);
        if (n.chk) cmp("overflow", 16'(n.ovf), 16'(status.flags.overflow));
        if (n.full) cmp("neg zero carry", 16'(n.nzc), 16'(status.flags[3:1]));
        cmp("busy", 16'h0000, 16'(status.busy));
      end
    end
  end

  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(86));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    cmp("reset top", 16'h0007, 16'(status.top));
    cmp("reset word", 16'h0000, status.top_word);
    // Nine pushes wrap the eight-entry stack
    repeat (9) run(OFD_OP_PUSH_LITERAL, 16'($urandom));
    // Range edges for signed and unsigned add and subtract
    for (int j = 0; j < 2; j++) begin
      for (int o = 13; o <= 16; o++) begin
        run(OFD_OP_PUSH_LITERAL, j ? 16'h8000 : 16'h7fff);
        run(OFD_OP_PUSH_LITERAL, 16'h0001);
        run(ofd_op_e'(5'(o)), 16'h0000);
      end
    end
    run(OFD_OP_PUSH_LITERAL, 16'h0002);
    run(OFD_OP_SIGNED_TWOS_COMPLEMENT_NEGATE, 16'h0000);
    run(OFD_OP_UNSIGNED_ONES_COMPLEMENT_NEGATE, 16'h0000);
    run(OFD_OP_PUSH_LITERAL, 16'hffff);
    run(OFD_OP_PUSH_LITERAL, 16'hffff);
    run(OFD_OP_UNSIGNED_MULTIPLY, 16'h0000);
    run(OFD_OP_STORE_WORD_TO_DATA, 16'h0300);
    run(OFD_OP_PUSH_LITERAL, 16'h8000);
    run(OFD_OP_SIGNED_TWOS_COMPLEMENT_NEGATE, 16'h0000);
    run(OFD_OP_PUSH_LITERAL, 16'h0000);
    run(OFD_OP_UNSIGNED_DIVIDE, 16'h0000);
    // Random arithmetic, back to back; divisor kept nonzero
    repeat (40) begin
      run(OFD_OP_PUSH_LITERAL, 16'($urandom));
      run(OFD_OP_PUSH_LITERAL, 16'($urandom) | 16'h0001);
      run(ofd_op_e'(5'($urandom_range(13, 20))), 16'h0000);
    end
    run(OFD_OP_PUSH_DOUBLE_MINUS_ONE, 16'h0000);
    run(OFD_OP_PUSH_DOUBLE_ONE, 16'h0000);
    run(OFD_OP_SIGNED_DOUBLE_ADD, 16'h0000);
    run(OFD_OP_PUSH_LITERAL, 16'h7fff);
    run(OFD_OP_PUSH_LITERAL, 16'hffff);
    run(OFD_OP_PUSH_DOUBLE_ONE, 16'h0000);
    run(OFD_OP_SIGNED_DOUBLE_ADD, 16'h0000);
    run(OFD_OP_PUSH_DOUBLE_ZERO, 16'h0000);
    // Memory traffic against a stalling partner
    slow = 1'b1;
    for (int i = 0; i < 8; i++) begin
      mem_u.dmem[16'hfff8 + 16'(i)] = 16'($urandom);
      mem_u.dmem[16'h7ff8 + 16'(i)] = 16'($urandom);
    end
    mem_u.cmem[16'h0123] = 16'h1a2b;
    mem_u.cmem[16'h8123] = 16'h3c4d;
    mem_u.cmem[16'hfffe] = 16'h5e6f;
    run(OFD_OP_LOAD_WORD_FROM_DATA, 16'hffff);
    run(OFD_OP_LOAD_WORD_FROM_CODE, 16'hfffe);
    x = ms[mt];
    run(OFD_OP_NONDESTRUCTIVE_WORD_STORE, 16'h7ff8);
    wait_idle();
    cmp("kept store", x, mem_u.dmem[16'h7ff8]);
    x = mem_u.dmem[16'h7ff9];
    run(OFD_OP_PUSH_LITERAL, 16'h00a5);
    run(OFD_OP_STORE_BYTE_TO_DATA, 16'hfff3);
    run(OFD_OP_PUSH_LITERAL, 16'h005a);
    run(OFD_OP_STORE_BYTE_TO_DATA, 16'hfff2);
    wait_idle();
    cmp("byte pair", 16'h5aa5, mem_u.dmem[16'h7ff9]);
    run(OFD_OP_LOAD_BYTE_FROM_DATA, 16'hfff2);
    run(OFD_OP_LOAD_BYTE_FROM_DATA, 16'hffff);
    for (int b = 0; b < 2; b++) begin
      wait_idle();
      pc = {b[0], 15'($urandom)};
      run(OFD_OP_LOAD_BYTE_FROM_CODE, 16'h0246);
      run(OFD_OP_LOAD_BYTE_FROM_CODE, 16'h0247);
    end
    // Double at the top of the segment, quad at an odd word
    run(OFD_OP_PUSH_LITERAL, 16'h1234);
    run(OFD_OP_PUSH_LITERAL, 16'h5678);
    run(OFD_OP_STORE_DOUBLE_TO_DATA, 16'hfffe);
    wait_idle();
    cmp("double ms", 16'h1234, mem_u.dmem[16'hfffe]);
    cmp("double ls", 16'h5678, mem_u.dmem[16'hffff]);
    run(OFD_OP_LOAD_DOUBLE_FROM_DATA, 16'hfffe);
    for (int i = 0; i < 4; i++) run(OFD_OP_PUSH_LITERAL, 16'h00c0 + 16'(i));
    run(OFD_OP_STORE_QUAD_TO_DATA, 16'hfff9);
    wait_idle();
    for (int i = 0; i < 4; i++) begin
      cmp("quad", 16'h00c0 + 16'(i), mem_u.dmem[16'hfff9 + 16'(i)]);
    end
    run(OFD_OP_LOAD_QUAD_FROM_DATA, 16'hfff9);
    wait_idle();
    repeat (3) @(negedge clk);
    cmp("notes left", 16'h0000, 16'(notes.size()));
    // Reset in mid-run puts the pointer and top word back to their start
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    cmp("rerun top", 16'h0007, 16'(status.top));
    cmp("rerun word", 16'h0000, status.top_word);
    complete_run();
  end
endmodule
`default_nettype wire
